// [src/trr_defs.vh]
// constants for the timer raw interrupt status block
`ifndef TRR_DEFS_VH
`define TRR_DEFS_VH

// register byte offsets
`define TRR_OFS_MODE_A     8'h04
`define TRR_OFS_MODE_B     8'h08
`define TRR_OFS_MASK       8'h18
`define TRR_OFS_RAW        8'h1C
`define TRR_OFS_MIS        8'h20
`define TRR_OFS_CLR        8'h24

// flag bit positions, shared by raw, mask, masked and clear registers
`define TRR_A_TIMEOUT      0
`define TRR_A_CAP_MATCH    1
`define TRR_A_CAP_EVENT    2
`define TRR_A_MATCH        4
`define TRR_A_DMA_DONE     5
`define TRR_B_TIMEOUT      8
`define TRR_B_CAP_MATCH    9
`define TRR_B_CAP_EVENT    10
`define TRR_B_MATCH        11
`define TRR_B_DMA_DONE     13

// implemented flag bits; everything else reads zero
`define TRR_FLAG_MASK      32'h00002F37
`define TRR_RAW_RESET      32'h00000000
`define TRR_MASK_RESET     32'h00000000

// sub-timer mode register fields
`define TRR_MODE_LSB       0
`define TRR_MODE_MSB       1
`define TRR_MODE_EDGE_TIME 2
`define TRR_MODE_COUNT_UP  4
`define TRR_MODE_MATCH_IE  5
`define TRR_MODE_PM_USE    6
`define TRR_MODE_W         7
`define TRR_MODE_WMASK     7'h77
`define TRR_MODE_RESET     7'h00

// timer mode field encodings
`define TRR_MD_ONE_SHOT    2'h1
`define TRR_MD_PERIODIC    2'h2
`define TRR_MD_CAPTURE     2'h3

`endif

// [src/trr_evt.v]
// per sub-timer event detector: turns counter state into one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
`include "trr_defs.vh"
module trr_evt #(
  parameter COUNT_W = 16,
  parameter PRE_W   = 8
) (
  input  wire               clk_sys,
  input  wire               rstn,
  input  wire [`TRR_MODE_W-1:0] mode_cfg,
  input  wire [COUNT_W-1:0] count_val,
  input  wire [PRE_W-1:0]   prescale_val,
  input  wire [COUNT_W-1:0] interval_load,
  input  wire [COUNT_W-1:0] match_val,
  input  wire [PRE_W-1:0]   prescale_match,
  input  wire               capture_event,
  input  wire               dma_done,
  output reg                timeout_pulse_ff,
  output reg                match_pulse_ff,
  output reg                cap_event_pulse_ff,
  output reg                cap_match_pulse_ff,
  output reg                dma_pulse_ff
);

  // count and prescale compare; prescale may be left out of the match
  function hit;
    input [COUNT_W-1:0] cnt;
    input [COUNT_W-1:0] mval;
    input [PRE_W-1:0]   pre;
    input [PRE_W-1:0]   pmval;
    input               use_pre;
    begin
      hit = (cnt == mval) && (!use_pre || (pre == pmval));
    end
  endfunction

  wire [1:0] mode_sel = mode_cfg[`TRR_MODE_MSB:`TRR_MODE_LSB];
  wire       timed    = (mode_sel == `TRR_MD_ONE_SHOT) ||
                        (mode_sel == `TRR_MD_PERIODIC);
  wire       edge_time = (mode_sel == `TRR_MD_CAPTURE) &&
                         mode_cfg[`TRR_MODE_EDGE_TIME];
  // limit depends on direction: zero down, interval load up
  wire [COUNT_W-1:0] limit = mode_cfg[`TRR_MODE_COUNT_UP] ?
                             interval_load : {COUNT_W{1'b0}};
  wire to_hit = timed && (count_val == limit);
  wire m_hit  = timed && mode_cfg[`TRR_MODE_MATCH_IE] &&
                hit(count_val, match_val, prescale_val, prescale_match,
                    mode_cfg[`TRR_MODE_PM_USE]);
  wire cm_hit = edge_time &&
                hit(count_val, match_val, prescale_val, prescale_match,
                    1'b1);

  reg to_prev_ff;
  reg m_prev_ff;
  reg cm_prev_ff;

  // a compare that holds for many cycles must not refire after a clear,
  // so only the arrival at the value makes a pulse
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      to_prev_ff         <= 1'b0;
      m_prev_ff          <= 1'b0;
      cm_prev_ff         <= 1'b0;
      timeout_pulse_ff   <= 1'b0;
      match_pulse_ff     <= 1'b0;
      cap_event_pulse_ff <= 1'b0;
      cap_match_pulse_ff <= 1'b0;
      dma_pulse_ff       <= 1'b0;
    end
    else
    begin
      to_prev_ff         <= to_hit;
      m_prev_ff          <= m_hit;
      cm_prev_ff         <= cm_hit;
      timeout_pulse_ff   <= to_hit & ~to_prev_ff;
      match_pulse_ff     <= m_hit & ~m_prev_ff;
      cap_event_pulse_ff <= capture_event & edge_time;
      cap_match_pulse_ff <= cm_hit & ~cm_prev_ff;
      dma_pulse_ff       <= dma_done;
    end
  end

endmodule
`default_nettype wire

// [src/trr_top.v]
// timer raw interrupt status block: flags, mask, clear and register port
`timescale 1ns/1ns
`default_nettype none
`include "trr_defs.vh"
module trr_top #(
  parameter COUNT_W = 16,
  parameter PRE_W   = 8,
  parameter ADDR_W  = 8
) (
  input  wire               clk_sys,
  input  wire               rstn,
  // register port
  input  wire [ADDR_W-1:0]  reg_addr,
  input  wire [31:0]        reg_wdata,
  input  wire               reg_wr,
  input  wire               reg_rd,
  output reg  [31:0]        reg_rdata_ff,
  // interrupt line
  output reg                irq_ff,
  // sub-timer A counter state
  input  wire [COUNT_W-1:0] sub_a_count_value,
  input  wire [PRE_W-1:0]   sub_a_prescale_value,
  input  wire [COUNT_W-1:0] sub_a_interval_load,
  input  wire [COUNT_W-1:0] sub_a_match_value,
  input  wire [PRE_W-1:0]   sub_a_prescale_match,
  input  wire               sub_a_capture_event,
  input  wire               sub_a_dma_done,
  // sub-timer B counter state
  input  wire [COUNT_W-1:0] sub_b_count_value,
  input  wire [PRE_W-1:0]   sub_b_prescale_value,
  input  wire [COUNT_W-1:0] sub_b_interval_load,
  input  wire [COUNT_W-1:0] sub_b_match_value,
  input  wire [PRE_W-1:0]   sub_b_prescale_match,
  input  wire               sub_b_capture_event,
  input  wire               sub_b_dma_done
);

  // address compare, used by both the write and the read decode
  function sel;
    input [ADDR_W-1:0] a;
    input [7:0]        ofs;
    begin
      sel = (a == ofs[ADDR_W-1:0]);
    end
  endfunction

  reg  [`TRR_MODE_W-1:0] sub_a_mode_reg_ff;
  reg  [`TRR_MODE_W-1:0] sub_b_mode_reg_ff;
  reg  [`TRR_MODE_W-1:0] nxt_sub_a_mode_reg;
  reg  [`TRR_MODE_W-1:0] nxt_sub_b_mode_reg;
  reg  [31:0]            irq_mask_reg_ff;
  reg  [31:0]            nxt_irq_mask_reg;
  reg  [31:0]            timer_raw_irq_flags_ff;
  reg  [31:0]            nxt_timer_raw_irq_flags;
  reg  [31:0]            flag_set;
  reg  [31:0]            flag_clr;
  reg  [31:0]            rd_mux;
  wire [31:0]            masked_irq_status;

  wire a_timeout;
  wire a_match;
  wire a_cap_event;
  wire a_cap_match;
  wire a_dma;
  wire b_timeout;
  wire b_match;
  wire b_cap_event;
  wire b_cap_match;
  wire b_dma;

  // sub-timer A events
  trr_evt #(
    .COUNT_W (COUNT_W),
    .PRE_W   (PRE_W)
  ) u_evt_a (
    .clk_sys            (clk_sys),
    .rstn               (rstn),
    .mode_cfg           (sub_a_mode_reg_ff),
    .count_val          (sub_a_count_value),
    .prescale_val       (sub_a_prescale_value),
    .interval_load      (sub_a_interval_load),
    .match_val          (sub_a_match_value),
    .prescale_match     (sub_a_prescale_match),
    .capture_event      (sub_a_capture_event),
    .dma_done           (sub_a_dma_done),
    .timeout_pulse_ff   (a_timeout),
    .match_pulse_ff     (a_match),
    .cap_event_pulse_ff (a_cap_event),
    .cap_match_pulse_ff (a_cap_match),
    .dma_pulse_ff       (a_dma)
  );

  // sub-timer B events
  trr_evt #(
    .COUNT_W (COUNT_W),
    .PRE_W   (PRE_W)
  ) u_evt_b (
    .clk_sys            (clk_sys),
    .rstn               (rstn),
    .mode_cfg           (sub_b_mode_reg_ff),
    .count_val          (sub_b_count_value),
    .prescale_val       (sub_b_prescale_value),
    .interval_load      (sub_b_interval_load),
    .match_val          (sub_b_match_value),
    .prescale_match     (sub_b_prescale_match),
    .capture_event      (sub_b_capture_event),
    .dma_done           (sub_b_dma_done),
    .timeout_pulse_ff   (b_timeout),
    .match_pulse_ff     (b_match),
    .cap_event_pulse_ff (b_cap_event),
    .cap_match_pulse_ff (b_cap_match),
    .dma_pulse_ff       (b_dma)
  );

  // gather the event pulses into the flag layout
  always @*
  begin
    flag_set                   = 32'h00000000;
    flag_set[`TRR_A_TIMEOUT]   = a_timeout;
    flag_set[`TRR_A_CAP_MATCH] = a_cap_match;
    flag_set[`TRR_A_CAP_EVENT] = a_cap_event;
    flag_set[`TRR_A_MATCH]     = a_match;
    flag_set[`TRR_A_DMA_DONE]  = a_dma;
    flag_set[`TRR_B_TIMEOUT]   = b_timeout;
    flag_set[`TRR_B_CAP_MATCH] = b_cap_match;
    flag_set[`TRR_B_CAP_EVENT] = b_cap_event;
    flag_set[`TRR_B_MATCH]     = b_match;
    flag_set[`TRR_B_DMA_DONE]  = b_dma;
  end

  // write one to clear; covers timer and dma flags alike
  always @*
  begin
    flag_clr = 32'h00000000;
    if (reg_wr && sel(reg_addr, `TRR_OFS_CLR))
    begin
      flag_clr = reg_wdata & `TRR_FLAG_MASK;
    end
  end

  // raw flags: sticky, set wins over clear so no event is lost;
  // the mask is not looked at here, and a write to the raw
  // offset itself has no path into this register
  always @*
  begin
    nxt_timer_raw_irq_flags = ((timer_raw_irq_flags_ff & ~flag_clr) |
                               flag_set) & `TRR_FLAG_MASK;
  end

  // mask and mode registers, written whole
  always @*
  begin
    nxt_irq_mask_reg   = irq_mask_reg_ff;
    nxt_sub_a_mode_reg = sub_a_mode_reg_ff;
    nxt_sub_b_mode_reg = sub_b_mode_reg_ff;
    if (reg_wr)
    begin
      if (sel(reg_addr, `TRR_OFS_MASK))
      begin
        nxt_irq_mask_reg = reg_wdata & `TRR_FLAG_MASK;
      end
      if (sel(reg_addr, `TRR_OFS_MODE_A))
      begin
        nxt_sub_a_mode_reg = reg_wdata[`TRR_MODE_W-1:0] & `TRR_MODE_WMASK;
      end
      if (sel(reg_addr, `TRR_OFS_MODE_B))
      begin
        nxt_sub_b_mode_reg = reg_wdata[`TRR_MODE_W-1:0] & `TRR_MODE_WMASK;
      end
    end
  end

  // masked view: what the interrupt line actually follows
  assign masked_irq_status = timer_raw_irq_flags_ff &
                             irq_mask_reg_ff;

  // read decode; the clear register and unmapped offsets read zero
  always @*
  begin
    rd_mux = 32'h00000000;
    case (1'b1)
      sel(reg_addr, `TRR_OFS_MODE_A):
        rd_mux = {{(32-`TRR_MODE_W){1'b0}}, sub_a_mode_reg_ff};
      sel(reg_addr, `TRR_OFS_MODE_B):
        rd_mux = {{(32-`TRR_MODE_W){1'b0}}, sub_b_mode_reg_ff};
      sel(reg_addr, `TRR_OFS_MASK):
        rd_mux = irq_mask_reg_ff;
      sel(reg_addr, `TRR_OFS_RAW):
        rd_mux = timer_raw_irq_flags_ff & `TRR_FLAG_MASK;
      sel(reg_addr, `TRR_OFS_MIS):
        rd_mux = masked_irq_status;
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  // state registers
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_raw_irq_flags_ff <= `TRR_RAW_RESET;
      irq_mask_reg_ff        <= `TRR_MASK_RESET;
      sub_a_mode_reg_ff      <= `TRR_MODE_RESET;
      sub_b_mode_reg_ff      <= `TRR_MODE_RESET;
    end
    else
    begin
      timer_raw_irq_flags_ff <= nxt_timer_raw_irq_flags;
      irq_mask_reg_ff        <= nxt_irq_mask_reg;
      sub_a_mode_reg_ff      <= nxt_sub_a_mode_reg;
      sub_b_mode_reg_ff      <= nxt_sub_b_mode_reg;
    end
  end

  // read data stand only in the cycle after the strobe, zero otherwise;
  // the interrupt trails the flags by one cycle to come from a flop
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata_ff <= 32'h00000000;
      irq_ff       <= 1'b0;
    end
    else
    begin
      reg_rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
      irq_ff       <= |masked_irq_status;
    end
  end

endmodule
`default_nettype wire

// [tb/trr_sva.sv]
// assertion checker for the raw interrupt status block
`timescale 1ns/1ns
`default_nettype none
module trr_sva #(
  parameter ADDR_W = 8
) (
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata_ff,
  input wire logic              irq_ff,
  input wire logic              sub_a_dma_done,
  input wire logic              sub_b_dma_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // read data must not linger, a stale word could be taken as a read
  rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata_ff == 32'h0)
    else $error("read data not zero outside a read");
  rsvd_bits_zero_a: assert property (
    reg_rd && reg_addr == 8'h1C |=> (reg_rdata_ff & 32'hFFFFD0C8) == 32'h0)
    else $error("reserved raw bit reads one");
  clr_reads_zero_a: assert property (
    reg_rd && reg_addr == 8'h24 |=> reg_rdata_ff == 32'h0)
    else $error("clear register reads nonzero");
  // irq and masked status come from the same state at the same edge
  irq_tracks_mis_a: assert property (
    reg_rd && reg_addr == 8'h20 |=> irq_ff == (reg_rdata_ff != 32'h0))
    else $error("irq disagrees with masked status");
  dma_a_set_a: assert property (sub_a_dma_done ##1 !reg_wr
    ##1 (reg_rd && reg_addr == 8'h1C) |=> reg_rdata_ff[5])
    else $error("dma A flag not set");
  dma_b_set_a: assert property (sub_b_dma_done ##1 !reg_wr
    ##1 (reg_rd && reg_addr == 8'h1C) |=> reg_rdata_ff[13])
    else $error("dma B flag not set");
  set_wins_a: assert property (sub_b_dma_done ##1 (reg_wr
    && reg_addr == 8'h24 && reg_wdata[13]) ##1 !reg_wr
    ##1 (reg_rd && reg_addr == 8'h1C) |=> reg_rdata_ff[13])
    else $error("clear beat a new dma B event");
  dma_clear_a: assert property ((reg_wr && reg_addr == 8'h24
    && reg_wdata[5] && !sub_a_dma_done && !$past(sub_a_dma_done))
    ##2 (reg_rd && reg_addr == 8'h1C) |=> !reg_rdata_ff[5])
    else $error("dma A flag not cleared");
endmodule
bind trr_top trr_sva #(.ADDR_W(ADDR_W)) u_trr_sva (.*);
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the raw interrupt status block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk_sys              = 1'h0;
  logic        rstn                 = 1'h0;
  logic [7:0]  reg_addr             = 8'h00;
  logic [31:0] reg_wdata            = 32'h0;
  logic        reg_wr               = 1'h0;
  logic        reg_rd               = 1'h0;
  wire  [31:0] reg_rdata_ff;
  wire         irq_ff;
  logic [15:0] sub_a_count_value    = 16'h0005;
  logic [7:0]  sub_a_prescale_value = 8'h00;
  logic [15:0] sub_a_interval_load  = 16'h0080;
  logic [15:0] sub_a_match_value    = 16'h0000;
  logic [7:0]  sub_a_prescale_match = 8'h03;
  logic        sub_a_capture_event  = 1'h0;
  logic        sub_a_dma_done       = 1'h0;
  logic [15:0] sub_b_count_value    = 16'h0001;
  logic [7:0]  sub_b_prescale_value = 8'h00;
  logic [15:0] sub_b_interval_load  = 16'h0040;
  logic [15:0] sub_b_match_value    = 16'h0000;
  logic [7:0]  sub_b_prescale_match = 8'h00;
  logic        sub_b_capture_event  = 1'h0;
  logic        sub_b_dma_done       = 1'h0;
  int          failures             = 0;
  int          n_compared           = 0;

  trr_top u_trr_top (.*);

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // an idle cycle after each write keeps back-to-back strobes race free
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    @(posedge clk_sys);
  endtask
  // data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    @(posedge clk_sys);
    chk(reg_rdata_ff, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic t_regs;
    rd(8'h1C, 32'h0);
    rd(8'h18, 32'h0);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'h2F37);
    wr(8'h18, 32'h0);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h00, 32'h0);
  endtask
  // capture pulse outside edge-time mode and match without enable
  task automatic t_timeout;
    wr(8'h04, 32'h02);
    wr(8'h08, 32'h12);
    sub_a_count_value <= 16'h0000;
    sub_b_count_value <= 16'h0040;
    sub_a_capture_event <= 1'h1;
    @(posedge clk_sys);
    sub_a_capture_event <= 1'h0;
    tick(2);
    rd(8'h1C, 32'h101);
    wr(8'h18, 32'h1);
    tick(2);
    chk(irq_ff, 32'h1);
    rd(8'h20, 32'h1);
    rd(8'h1C, 32'h101);
    wr(8'h24, 32'h101);
    rd(8'h1C, 32'h0);
    chk(irq_ff, 32'h0);
  endtask
  task automatic t_match;
    sub_a_count_value <= 16'h0010;
    sub_b_count_value <= 16'h0010;
    sub_a_match_value <= 16'h0030;
    sub_b_match_value <= 16'h0020;
    wr(8'h04, 32'h21);
    wr(8'h08, 32'h31);
    sub_a_count_value <= 16'h0030;
    sub_b_count_value <= 16'h0020;
    tick(3);
    rd(8'h1C, 32'h810);
    wr(8'h24, 32'h810);
    rd(8'h1C, 32'h0);
    // prescale match in use: a prescale mismatch holds the match off
    wr(8'h04, 32'h61);
    tick(2);
    rd(8'h1C, 32'h0);
    sub_a_prescale_value <= 8'h03;
    tick(3);
    rd(8'h1C, 32'h10);
    sub_a_prescale_value <= 8'h00;
    wr(8'h24, 32'h10);
    rd(8'h1C, 32'h0);
  endtask
  // prescale mismatch holds off the A capture match
  task automatic t_capture;
    sub_a_count_value <= 16'h0011;
    sub_b_count_value <= 16'h0011;
    wr(8'h04, 32'h07);
    wr(8'h08, 32'h07);
    sub_a_capture_event <= 1'h1;
    sub_b_capture_event <= 1'h1;
    sub_a_count_value <= 16'h0030;
    sub_b_count_value <= 16'h0020;
    @(posedge clk_sys);
    sub_a_capture_event <= 1'h0;
    sub_b_capture_event <= 1'h0;
    tick(2);
    rd(8'h1C, 32'h604);
    sub_a_prescale_value <= 8'h03;
    tick(3);
    rd(8'h1C, 32'h606);
    wr(8'h24, 32'h2F37);
  endtask
  task automatic t_dma;
    sub_a_dma_done <= 1'h1;
    sub_b_dma_done <= 1'h1;
    @(posedge clk_sys);
    sub_a_dma_done <= 1'h0;
    sub_b_dma_done <= 1'h0;
    @(posedge clk_sys);
    rd(8'h1C, 32'h2020);
    wr(8'h24, 32'h20);
    rd(8'h1C, 32'h2000);
    sub_b_dma_done <= 1'h1;
    @(posedge clk_sys);
    sub_b_dma_done <= 1'h0;
    wr(8'h24, 32'h2000);
    rd(8'h1C, 32'h2000);
    wr(8'h24, 32'h2000);
    rd(8'h1C, 32'h0);
  endtask
  // a reset in mid-run drops every flag, the mask and the interrupt
  task automatic t_reset;
    sub_a_dma_done <= 1'h1;
    @(posedge clk_sys);
    sub_a_dma_done <= 1'h0;
    wr(8'h18, 32'h20);
    tick(1);
    chk(irq_ff, 32'h1);
    rstn <= 1'h0;
    tick(3);
    rstn <= 1'h1;
    chk(irq_ff, 32'h0);
    @(posedge clk_sys);
    rd(8'h1C, 32'h0);
    rd(8'h18, 32'h0);
  endtask
  task automatic summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence
  initial
  begin
    tick(3);
    rstn <= 1'h1;
    @(posedge clk_sys);
    t_regs();
    t_timeout();
    t_match();
    t_capture();
    t_dma();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
